/* File: design/bfm_defines.svh */
`ifndef BFM_DEFINES_SVH
`define BFM_DEFINES_SVH

// register byte offsets on the slave bus
`define BFM_OFS_CMD      8'h00
`define BFM_OFS_MASK     8'h04
`define BFM_OFS_ADDR     8'h08
`define BFM_OFS_STAT     8'h0C
`define BFM_OFS_STW      8'h10
`define BFM_OFS_ACC0L    8'h14
`define BFM_OFS_ACC0H    8'h18
`define BFM_OFS_ACC1L    8'h1C
`define BFM_OFS_ACC1H    8'h20
`define BFM_WIN_BIT      7

// command word fields
`define BFM_CMD_OP       0
`define BFM_CMD_FORM_LSB 1
`define BFM_CMD_FORM_MSB 3
`define BFM_CMD_IDX_LSB  4
`define BFM_CMD_IDX_MSB  8
`define BFM_CMD_OFS_LSB  10
`define BFM_CMD_OFS_MSB  15

// status register fields
`define BFM_ST_BUSY      0
`define BFM_ST_DONE      1
`define BFM_ST_ILL       2
`define BFM_ST_WORDS_LSB 4
`define BFM_ST_WORDS_MSB 5
`define BFM_ST_CYC_LSB   8
`define BFM_ST_CYC_MSB   11

// register operand field codes
`define BFM_IDX_STACK    5'h1F
`define BFM_IDX_R2       5'h12
`define BFM_IDX_SP       5'h17
`define BFM_IDX_STW      5'h19
`define BFM_IDX_ACC0     5'h0E
`define BFM_IDX_ACC1     5'h0F

// short address regions
`define BFM_ZP_BASE      10'h000
`define BFM_IO_BASE      10'h3FF

// cycle and program word counts
`define BFM_CYC_SHORT    4'h4
`define BFM_CYC_LONG     4'h6
`define BFM_WORDS_SHORT  2'h2
`define BFM_WORDS_LONG   2'h3

// condition code bits and values
`define BFM_STW_C        0
`define BFM_STW_L        6
`define BFM_STW_RESET    16'h0000
`define BFM_SAT_POS      16'h7FFF
`define BFM_SAT_NEG      16'h8000

`endif

/* File: design/bfm_pkg.sv */
package bfm_pkg;
  // addressing forms as coded in the command word
  typedef enum logic [2:0] {
    FORM_REG  = 3'h0,
    FORM_PTR  = 3'h1,
    FORM_STK  = 3'h2,
    FORM_ABS  = 3'h3,
    FORM_IO   = 3'h4,
    FORM_LONG = 3'h5
  } bfm_form_t;

  typedef enum {BUS_IDLE, BUS_WAIT, BUS_DONE} bfm_bus_t;

  typedef enum {ENG_IDLE, ENG_PTR, ENG_ADDR, ENG_WAIT, ENG_CAPT,
                ENG_WRITE, ENG_PAD} bfm_eng_t;
endpackage : bfm_pkg

/* File: design/bfm_regfile.sv */
`timescale 1ns/1ps
module bfm_regfile (
  input  wire logic        ref_clk,
  input  wire logic        rstSync_b,
  input  wire logic        wrEn,
  input  wire logic [4:0]  wrAddr,
  input  wire logic [15:0] wrData,
  input  wire logic        rdEn,
  input  wire logic [4:0]  rdAddr,
  output logic      [15:0] rdData
);
  logic [15:0] mem [0:31];

  // storage has no reset, software loads what it needs
  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // read data held until the next read
  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      rdData <= 16'h0000;
    end else if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule : bfm_regfile

/* File: design/bfm_unit.sv */
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`include "bfm_defines.svh"
// What this block does
// - carry set when all mask-selected bits are one, else cleared, except with the status word as destination
// - clear operation forces selected bits to zero, others kept
// - set operation forces selected bits to one, others kept
// - hardware stack register is an illegal register destination
// - short absolute form takes a 6-bit data-memory address
// - short I/O form takes a 6-bit address in the peripheral region
// - register, short absolute and short I/O forms take 4 cycles, 2 words
// - pointer-offset and stack-offset forms take 6 cycles, 2 words
// - long absolute form takes 6 cycles, 3 words
// - limit flag set when a 36-bit accumulator source saturates
// - all-zero mask leaves destination unchanged and sets carry, except with the status word as destination
// - status word destination takes the mask operation directly
module bfm_unit import bfm_pkg::*; (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             memRd,
  output logic             memWr,
  output logic      [15:0] memAddr,
  output logic      [15:0] memWdata,
  input  wire logic [15:0] memRdata,
  output logic             busy,
  output logic      [15:0] statusWord
);
  logic        rstMeta_reg, rstSync_b;
  bfm_bus_t    busState_reg, busState_next;
  logic [31:0] readData_next;
  logic        waitReq_next;
  bfm_eng_t    eState_reg, eState_next;
  logic [3:0]  cnt_reg, cnt_next, total_reg, total_next;
  logic [1:0]  words_reg, words_next;
  logic        op_reg, op_next, busy_next;
  bfm_form_t   form_reg, form_next, cmdForm;
  logic [4:0]  idx_reg, idx_next, rfRdAddr;
  logic [5:0]  ofs_reg, ofs_next;
  logic [15:0] opMask_reg, opMask_next, mask_reg, mask_next;
  logic [15:0] longAddr_reg, longAddr_next, statusWord_next;
  logic [35:0] acc_reg [2], acc_next [2];
  logic        done_reg, done_next, illegal_reg, illegal_next;
  logic        memRd_next, memWr_next;
  logic [15:0] memAddr_next, memWdata_next;
  logic        rfWe, rfRe, limited, carryVal, start, wrCommit;
  logic [15:0] rfRdata, rfWdata, operandVal, resultVal;
  logic [35:0] accSrc;
  logic        memForm, stwDest, accDest;
  logic [31:0] maskMerged;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_reg <= 1'b0;
      rstSync_b   <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_b   <= rstMeta_reg;
    end
  end

  function automatic logic [31:0] beMerge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : beMerge

  // bus slave: request seen, data ready, answer with waitrequest low
  always_comb begin
    busState_next = busState_reg;
    readData_next = avs_readdata;
    waitReq_next  = 1'b1;
    case (busState_reg)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          busState_next = BUS_WAIT;
        end
      end
      BUS_WAIT: begin
        busState_next = BUS_DONE;
        waitReq_next  = 1'b0;
        readData_next = 32'h0000_0000;  // unmapped reads as zero
        if (avs_read && avs_address[`BFM_WIN_BIT]) begin
          readData_next = busy ? 32'h0000_0000 : {16'h0000, rfRdata};
        end else if (avs_read) begin
          case (avs_address)
            `BFM_OFS_MASK:  readData_next = {16'h0000, mask_reg};
            `BFM_OFS_ADDR:  readData_next = {16'h0000, longAddr_reg};
            `BFM_OFS_STW:   readData_next = {16'h0000, statusWord};
            `BFM_OFS_ACC0L: readData_next = acc_reg[0][31:0];
            `BFM_OFS_ACC0H: readData_next = {28'h0000000, acc_reg[0][35:32]};
            `BFM_OFS_ACC1L: readData_next = acc_reg[1][31:0];
            `BFM_OFS_ACC1H: readData_next = {28'h0000000, acc_reg[1][35:32]};
            `BFM_OFS_STAT: begin
              readData_next[`BFM_ST_BUSY] = busy;
              readData_next[`BFM_ST_DONE] = done_reg;
              readData_next[`BFM_ST_ILL]  = illegal_reg;
              readData_next[`BFM_ST_WORDS_MSB:`BFM_ST_WORDS_LSB] = words_reg;
              readData_next[`BFM_ST_CYC_MSB:`BFM_ST_CYC_LSB] = total_reg;
            end
            default: readData_next = 32'h0000_0000;
          endcase
        end
      end
      BUS_DONE: busState_next = BUS_IDLE;
      default:  busState_next = BUS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      busState_reg    <= BUS_IDLE;
      avs_readdata    <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end else begin
      busState_reg    <= busState_next;
      avs_readdata    <= readData_next;
      avs_waitrequest <= waitReq_next;
    end
  end

  // a write takes effect at the edge that ends its waitrequest-low cycle
  assign wrCommit = (busState_reg == BUS_DONE) && avs_write;
  assign start    = wrCommit && !busy && (avs_address == `BFM_OFS_CMD);
  assign cmdForm  = bfm_form_t'(
                    avs_writedata[`BFM_CMD_FORM_MSB:`BFM_CMD_FORM_LSB]);
  // byte lanes merged over the mask, upper half dropped on purpose
  assign maskMerged = beMerge({16'h0000, mask_reg}, avs_writedata,
                              avs_byteenable);

  // destination classification and operand selection
  assign memForm  = (form_reg != FORM_REG);
  assign stwDest  = !memForm && (idx_reg == `BFM_IDX_STW);
  assign accDest  = !memForm && ((idx_reg == `BFM_IDX_ACC0) ||
                                 (idx_reg == `BFM_IDX_ACC1));
  assign accSrc   = acc_reg[idx_reg[0]];
  assign limited  = accDest && !((&accSrc[35:31]) || !(|accSrc[35:31]));

  always_comb begin
    operandVal = rfRdata;
    if (memForm) begin
      operandVal = memRdata;
    end else if (stwDest) begin
      operandVal = statusWord;
    end else if (accDest) begin
      operandVal = limited ? (accSrc[35] ? `BFM_SAT_NEG : `BFM_SAT_POS)
                           : accSrc[31:16];
    end
  end

  // all selected ones; a zero mask always matches
  assign carryVal  = ((operandVal & opMask_reg) == opMask_reg);
  // clear or set the selected bits
  assign resultVal = op_reg ? (operandVal | opMask_reg)
                            : (operandVal & ~opMask_reg);

  // regfile port use: engine owns it while busy, bus only when idle
  assign rfRdAddr = (eState_reg == ENG_PTR) ?
                    ((form_reg == FORM_PTR) ? `BFM_IDX_R2 : `BFM_IDX_SP) :
                    (busy ? idx_reg : avs_address[6:2]);
  assign rfRe = (eState_reg == ENG_PTR) ||
                ((eState_reg == ENG_ADDR) && !memForm) ||
                (!busy && (busState_reg == BUS_IDLE) && avs_read &&
                 avs_address[`BFM_WIN_BIT]);
  assign rfWe = ((eState_reg == ENG_CAPT) && !memForm && !stwDest &&
                 !accDest && (opMask_reg != 16'h0000)) ||
                (wrCommit && !busy && avs_address[`BFM_WIN_BIT]);
  assign rfWdata = busy ? resultVal : avs_writedata[15:0];

  bfm_regfile u_regfile (
    .ref_clk   (ref_clk),
    .rstSync_b (rstSync_b),
    .wrEn      (rfWe),
    .wrAddr    (busy ? idx_reg : avs_address[6:2]),
    .wrData    (rfWdata),
    .rdEn      (rfRe),
    .rdAddr    (rfRdAddr),
    .rdData    (rfRdata)
  );

  // engine and software-visible control state
  always_comb begin
    eState_next   = eState_reg;
    cnt_next      = busy ? cnt_reg + 4'h1 : 4'h0;
    total_next    = total_reg;
    words_next    = words_reg;
    op_next       = op_reg;
    form_next     = form_reg;
    idx_next      = idx_reg;
    ofs_next      = ofs_reg;
    opMask_next   = opMask_reg;
    mask_next     = mask_reg;
    longAddr_next = longAddr_reg;
    statusWord_next = statusWord;
    acc_next      = acc_reg;
    done_next     = done_reg;
    illegal_next  = illegal_reg;
    busy_next     = busy;
    memRd_next    = 1'b0;
    memWr_next    = 1'b0;
    memAddr_next  = memAddr;
    memWdata_next = memWdata;
    // software writes are refused while an operation runs
    if (wrCommit && !busy) begin
      case (avs_address)
        `BFM_OFS_MASK: mask_next = maskMerged[15:0];
        `BFM_OFS_ADDR: longAddr_next = avs_writedata[15:0];
        `BFM_OFS_STW:  statusWord_next = avs_writedata[15:0];
        `BFM_OFS_ACC0L: acc_next[0][31:0] = beMerge(acc_reg[0][31:0],
                          avs_writedata, avs_byteenable);
        `BFM_OFS_ACC0H: acc_next[0][35:32] = avs_writedata[3:0];
        `BFM_OFS_ACC1L: acc_next[1][31:0] = beMerge(acc_reg[1][31:0],
                          avs_writedata, avs_byteenable);
        `BFM_OFS_ACC1H: acc_next[1][35:32] = avs_writedata[3:0];
        `BFM_OFS_STAT: begin
          if (avs_writedata[`BFM_ST_DONE]) done_next = 1'b0;
          if (avs_writedata[`BFM_ST_ILL])  illegal_next = 1'b0;
        end
        default: ;
      endcase
    end
    if (start) begin
      op_next      = avs_writedata[`BFM_CMD_OP];
      form_next    = cmdForm;
      idx_next     = avs_writedata[`BFM_CMD_IDX_MSB:`BFM_CMD_IDX_LSB];
      ofs_next     = avs_writedata[`BFM_CMD_OFS_MSB:`BFM_CMD_OFS_LSB];
      opMask_next  = mask_reg;
      done_next    = 1'b0;
      illegal_next = 1'b0;
      // cycle and word counts per form
      total_next = (cmdForm == FORM_PTR || cmdForm == FORM_STK ||
                    cmdForm == FORM_LONG) ? `BFM_CYC_LONG : `BFM_CYC_SHORT;
      words_next = (cmdForm == FORM_LONG) ? `BFM_WORDS_LONG
                                          : `BFM_WORDS_SHORT;
      busy_next  = 1'b1;
      case (cmdForm)
        FORM_REG: begin
          if (avs_writedata[`BFM_CMD_IDX_MSB:`BFM_CMD_IDX_LSB] ==
              `BFM_IDX_STACK) begin
            illegal_next = 1'b1;
            busy_next    = 1'b0;
          end else begin
            eState_next = ENG_ADDR;
          end
        end
        FORM_PTR, FORM_STK: eState_next = ENG_PTR;
        FORM_ABS: begin
          memAddr_next = {`BFM_ZP_BASE,
                          avs_writedata[`BFM_CMD_OFS_MSB:`BFM_CMD_OFS_LSB]};
          memRd_next   = 1'b1;
          eState_next  = ENG_WAIT;
        end
        FORM_IO: begin
          memAddr_next = {`BFM_IO_BASE,
                          avs_writedata[`BFM_CMD_OFS_MSB:`BFM_CMD_OFS_LSB]};
          memRd_next   = 1'b1;
          eState_next  = ENG_WAIT;
        end
        FORM_LONG: begin
          memAddr_next = longAddr_reg;
          memRd_next   = 1'b1;
          eState_next  = ENG_WAIT;
        end
        default: begin
          illegal_next = 1'b1;
          busy_next    = 1'b0;
        end
      endcase
    end
    case (eState_reg)
      ENG_IDLE: ;
      ENG_PTR:  eState_next = ENG_ADDR;
      ENG_ADDR: begin
        if (!memForm) begin
          eState_next = ENG_CAPT;
        end else begin
          memAddr_next = (form_reg == FORM_PTR) ?
                         rfRdata + {10'h000, ofs_reg} :
                         rfRdata - {10'h000, ofs_reg};
          memRd_next   = 1'b1;
          eState_next  = ENG_WAIT;
        end
      end
      ENG_WAIT: eState_next = ENG_CAPT;
      ENG_CAPT: begin
        eState_next = ENG_WRITE;
        // status word takes the result directly
        if (stwDest) begin
          statusWord_next = resultVal;
        end else begin
          // carry in bit 0, limit in bit 6
          statusWord_next[`BFM_STW_C] = carryVal;
          if (limited) statusWord_next[`BFM_STW_L] = 1'b1;
        end
        if (opMask_reg != 16'h0000) begin
          // write back to the address just read
          if (memForm) begin
            memWr_next    = 1'b1;
            memWdata_next = resultVal;
          end else if (accDest) begin
            acc_next[idx_reg[0]] = {{4{resultVal[15]}}, resultVal, 16'h0000};
          end
        end
      end
      ENG_WRITE: eState_next = ENG_PAD;
      ENG_PAD: begin
        if (cnt_reg == total_reg - 4'h1) begin
          eState_next = ENG_IDLE;
          busy_next   = 1'b0;
          done_next   = 1'b1;  // set after any clear in the same cycle
        end
      end
      default: eState_next = ENG_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      eState_reg   <= ENG_IDLE;
      cnt_reg      <= 4'h0;
      total_reg    <= 4'h0;
      words_reg    <= 2'h0;
      op_reg       <= 1'b0;
      form_reg     <= FORM_REG;
      idx_reg      <= 5'h00;
      ofs_reg      <= 6'h00;
      opMask_reg   <= 16'h0000;
      mask_reg     <= 16'h0000;
      longAddr_reg <= 16'h0000;
      statusWord   <= `BFM_STW_RESET;
      acc_reg[0]   <= 36'h0_0000_0000;
      acc_reg[1]   <= 36'h0_0000_0000;
      done_reg     <= 1'b0;
      illegal_reg  <= 1'b0;
      busy         <= 1'b0;
      memRd        <= 1'b0;
      memWr        <= 1'b0;
      memAddr      <= 16'h0000;
      memWdata     <= 16'h0000;
    end else begin
      eState_reg   <= eState_next;
      cnt_reg      <= cnt_next;
      total_reg    <= total_next;
      words_reg    <= words_next;
      op_reg       <= op_next;
      form_reg     <= form_next;
      idx_reg      <= idx_next;
      ofs_reg      <= ofs_next;
      opMask_reg   <= opMask_next;
      mask_reg     <= mask_next;
      longAddr_reg <= longAddr_next;
      statusWord   <= statusWord_next;
      acc_reg      <= acc_next;
      done_reg     <= done_next;
      illegal_reg  <= illegal_next;
      busy         <= busy_next;
      memRd        <= memRd_next;
      memWr        <= memWr_next;
      memAddr      <= memAddr_next;
      memWdata     <= memWdata_next;
    end
  end

  // checks on the engine
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstSync_b);

  wire capt = (eState_reg == ENG_CAPT);
  wire shortGo = start && (cmdForm == FORM_ABS || cmdForm == FORM_IO ||
    (cmdForm == FORM_REG && avs_writedata[8:4] != `BFM_IDX_STACK));

  a_carry_flag: assert property (
    capt && !stwDest |=> statusWord[0] == $past(carryVal))
    else $error("carry does not match selected bits");
  a_clear_bits: assert property (
    capt && memForm && !op_reg && opMask_reg != 16'h0000 |=>
    memWr && memWdata == ($past(operandVal) & ~$past(opMask_reg)))
    else $error("clear result wrong");
  a_set_bits: assert property (
    capt && memForm && op_reg && opMask_reg != 16'h0000 |=>
    memWr && memWdata == ($past(operandVal) | $past(opMask_reg)))
    else $error("set result wrong");
  a_stack_refused: assert property (
    start && cmdForm == FORM_REG && avs_writedata[8:4] == `BFM_IDX_STACK
    |=> !busy && illegal_reg)
    else $error("stack register accepted");
  a_short_abs: assert property (
    start && cmdForm == FORM_ABS |=>
    memRd && memAddr == {10'h000, $past(avs_writedata[15:10])})
    else $error("short absolute address wrong");
  a_short_io: assert property (
    start && cmdForm == FORM_IO |=>
    memRd && memAddr == {10'h3FF, $past(avs_writedata[15:10])})
    else $error("short io address wrong");
  a_short_cycles: assert property (
    shortGo |=> (busy && words_reg == 2'h2)[*4] ##1 !busy)
    else $error("short form not four cycles");
  a_ptr_cycles: assert property (
    start && (cmdForm == FORM_PTR || cmdForm == FORM_STK) |=>
    (busy && words_reg == 2'h2)[*6] ##1 !busy)
    else $error("offset form not six cycles");
  a_long_cycles: assert property (
    start && cmdForm == FORM_LONG |=>
    (busy && words_reg == 2'h3)[*6] ##1 (!busy && done_reg))
    else $error("long form not six cycles");
  a_limit_flag: assert property (
    capt && limited |=> statusWord[6])
    else $error("limit flag not set");
  a_zero_mask: assert property (
    capt && opMask_reg == 16'h0000 && !stwDest |=> !memWr && statusWord[0])
    else $error("zero mask modified destination");
  a_status_dest: assert property (
    capt && stwDest |=> statusWord == $past(resultVal))
    else $error("status word result wrong");
  a_same_addr: assert property (
    memWr |-> $past(memRd, 2) && memAddr == $past(memAddr, 2))
    else $error("write-back address differs");

  c_mem_clear: cover property (capt && memForm && !op_reg ##2 memWr);
  c_reg_set: cover property (capt && !memForm && op_reg);
  c_limited: cover property (capt && limited);
  c_illegal: cover property (illegal_reg && !busy);
endmodule : bfm_unit

/* File: tb/bfm_mem_model.sv */
`timescale 1ns/1ps
// data memory and peripheral space behind the unit, fixed read latency
module bfm_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        memRd,
  input  wire logic        memWr,
  input  wire logic [15:0] memAddr,
  input  wire logic [15:0] memWdata,
  output logic      [15:0] memRdata
);
  logic [15:0] mem [0:65535];
  int          wrCount = 0;

  // read then write-back; unloaded words read unknown
  always @(posedge ref_clk) begin
    if (memRd) begin
      memRdata <= mem[memAddr];
    end else begin
      memRdata <= ~memRdata;  // idle bus keeps toggling, never looks valid
    end
    if (memWr) begin
      mem[memAddr] <= memWdata;
      wrCount      <= wrCount + 1;
    end
  end
endmodule : bfm_mem_model

/* File: tb/bitfield_test_modify_unit_bench.sv */
`timescale 1ns/1ps
module bitfield_test_modify_unit_bench import bfm_pkg::*;;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        memRd;
  logic        memWr;
  logic        busy;
  logic [15:0] memAddr;
  logic [15:0] memWdata;
  logic [15:0] memRdata;
  logic [15:0] statusWord;
  int          num_errors = 0;
  int          tests_run = 0;
  int          busyCount;
  logic [31:0] rd;

  // 50 MHz core clock
  always #10 ref_clk = ~ref_clk;

  bfm_unit bfm_unit_inst (
    .ref_clk, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .memRd, .memWr, .memAddr, .memWdata,
    .memRdata, .busy, .statusWord
  );

  bfm_mem_model bfm_mem_model_inst (
    .ref_clk, .memRd, .memWr, .memAddr, .memWdata, .memRdata
  );

  task automatic print_verdict;
    if (num_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // one bus access, held until waitrequest is sampled low
  task automatic bus_acc(input bit wr, input logic [7:0] a,
                         input logic [31:0] d);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus_acc

  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk

  function automatic logic [15:0] cw(bit s, bfm_form_t f,
                                     logic [4:0] i, logic [5:0] o);
    return {o, 1'b0, i, f, s};
  endfunction : cw

  function automatic logic [15:0] mv(logic [15:0] a);
    return bfm_mem_model_inst.mem[a];
  endfunction : mv

  // load mask, start, count busy cycles, then fetch status
  task automatic run(input logic [15:0] m, input logic [15:0] c);
    bus_acc(1, 8'h04, {16'h0, m});
    bus_acc(1, 8'h00, {16'h0, c});
    busyCount = 0;
    repeat (12) begin
      @(posedge ref_clk);
      busyCount += (busy === 1'b1);
    end
    bus_acc(0, 8'h0C, 32'h0);
  endtask : run

  // hang guard, about fifteen times the expected run
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    print_verdict();
  end

  // main sequence
  initial begin
    bfm_mem_model_inst.mem[16'hFFE2] = 16'h7F95;
    bfm_mem_model_inst.mem[16'h0005] = 16'h8921;
    bfm_mem_model_inst.mem[16'h0007] = 16'hFFFF;
    bfm_mem_model_inst.mem[16'h1234] = 16'h00F0;
    bfm_mem_model_inst.mem[16'h0103] = 16'h1111;
    bfm_mem_model_inst.mem[16'h01FE] = 16'h0000;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    run(16'h0310, cw(0, FORM_IO, 0, 6'h22));
    chk("io mem", 16'h7C85, mv(16'hFFE2));
    chk("carry", 1, statusWord[0]);
    chk("busy", 4, busyCount);
    chk("stat", 6'h12, {rd[11:8], rd[5:4]});
    chk("writes", 1, bfm_mem_model_inst.wrCount);
    run(16'hF400, cw(1, FORM_ABS, 0, 6'h05));
    chk("abs mem", 16'hFD21, mv(16'h0005));
    chk("carry", 0, statusWord[0]);
    run(16'h00F0, cw(0, FORM_ABS, 0, 6'h07));
    chk("abs clr", 16'hFF0F, mv(16'h0007));
    chk("carry", 1, statusWord[0]);
    bus_acc(1, 8'h10, 32'h0);
    run(16'h0000, cw(1, FORM_ABS, 0, 6'h07));
    chk("zero mask", 16'hFF0F, mv(16'h0007));
    chk("writes", 3, bfm_mem_model_inst.wrCount);
    chk("carry", 1, statusWord[0]);
    bus_acc(1, 8'h08, 32'h1234);
    bus_acc(1, 8'h10, 32'h0);
    run(16'h00F0, cw(1, FORM_LONG, 0, 0));
    chk("busy", 6, busyCount);
    chk("stat", 6'h1B, {rd[11:8], rd[5:4]});
    chk("carry", 1, statusWord[0]);
    bus_acc(1, 8'hC8, 32'h0100);
    run(16'h0001, cw(0, FORM_PTR, 0, 6'h03));
    chk("ptr mem", 16'h1110, mv(16'h0103));
    chk("stat", 6'h1A, {rd[11:8], rd[5:4]});
    bus_acc(1, 8'hDC, 32'h0200);
    run(16'h8000, cw(1, FORM_STK, 0, 6'h02));
    chk("stk mem", 16'h8000, mv(16'h01FE));
    chk("busy", 6, busyCount);
    chk("carry", 0, statusWord[0]);
    bus_acc(1, 8'h8C, 32'h00FF);
    run(16'h000F, cw(0, FORM_REG, 5'h03, 0));
    chk("busy", 4, busyCount);
    bus_acc(0, 8'h8C, 32'h0);
    chk("reg dest", 16'h00F0, rd[15:0]);
    run(16'h0001, cw(0, FORM_REG, 5'h1F, 0));
    chk("busy", 0, busyCount);
    chk("illegal", 1, rd[2]);
    bus_acc(1, 8'h10, 32'h0);
    run(16'h0041, cw(1, FORM_REG, 5'h19, 0));
    chk("status dest", 16'h0041, statusWord);
    bus_acc(1, 8'h10, 32'h0);
    bus_acc(1, 8'h14, 32'h0);
    bus_acc(1, 8'h18, 32'h1);
    run(16'h0001, cw(0, FORM_REG, 5'h0E, 0));
    chk("limit", 1, statusWord[6]);
    chk("carry", 1, statusWord[0]);
    print_verdict();
  end
endmodule : bitfield_test_modify_unit_bench
